// ---- src/arc_defs.vh ----
// constants for the converter reference, channel and result registers
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH

// register byte addresses
`define ARC_ADDR_PORT_ANALOG_CONFIG 20'hf0017
`define ARC_ADDR_RESULT_WIDE_LO 20'hfff1e
`define ARC_ADDR_RESULT_HIGH_BYTE 20'hfff1f
`define ARC_ADDR_PORT_TWO_DIR 20'hfff22
`define ARC_ADDR_PORT_FIFTEEN_DIR 20'hfff2f
`define ARC_ADDR_CHANNEL_SELECT 20'hfff31
`define ARC_ADDR_REF_VOLTAGE_CTRL 20'hfff36

// reset values
`define ARC_RST_PORT_ANALOG_CONFIG 5'h10
`define ARC_RST_RESULT_WIDE 16'h0000
`define ARC_RST_RESULT_HIGH_BYTE 8'h00
`define ARC_RST_PORT_DIR 8'hff
`define ARC_RST_CHANNEL_SELECT 4'h0
`define ARC_RST_REF_VOLTAGE_CTRL 8'h00

// reference voltage control field positions
`define ARC_BIT_NEG_REF_SELECT 7
`define ARC_BIT_REF_OUTPUT_SELECT 3
`define ARC_BIT_REF_LEVEL_SELECT 1
`define ARC_BIT_REF_OUTPUT_ENABLE 0
`define ARC_REF_CTRL_MASK 8'h8b

// port fifteen direction: bits 6..3 fixed at one
`define ARC_PORT_FIFTEEN_FIXED 8'h78

// channel codes
`define ARC_CHAN_LAST_LOW 4'ha
`define ARC_CHAN_FIFTEEN 4'hf

// supply mode code of normal mode 1
`define ARC_SUPPLY_NORMAL_ONE 2'h0

`endif

// ---- src/arc_pin_map.v ----
// per-pin analog/digital decode and conversion eligibility
`timescale 1ns/1ps
`default_nettype none

module arc_pin_map #(
  parameter NPIN = 12
) (
  // configuration inputs
  input wire [4:0] port_config,
  input wire [NPIN-1:0] pin_input_mode,
  input wire [2:0] opamp_enable,
  input wire negative_ref_select,
  // per-pin decode results
  output wire [NPIN-1:0] pin_analog,
  output wire [NPIN-1:0] pin_convertible,
  output wire [NPIN-1:0] pin_opamp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // one slice per pin; pin 11 stands for channel 15
  genvar i;
  generate
    for (i = 0; i < NPIN; i = i + 1) begin : g_pin
      // channel number carried by this pin
      localparam [4:0] CHAN = (i == NPIN - 1) ? 5'h0f : i;
      // op-amp owning this pin, none above channel 8
      localparam integer AMP = (i < 9) ? (i / 3) : 0;
      localparam HAS_AMP = (i < 9);
      localparam IS_AMP_OUT = HAS_AMP && ((i % 3) == 1);
      wire amp_on;
      wire ref_pin_busy;
      assign amp_on = HAS_AMP ? opamp_enable[AMP] : 1'b0;
      // channel 15 pin doubles as the negative reference input
      assign ref_pin_busy = (i == NPIN - 1) ? negative_ref_select : 1'b0;
      // value k makes all channels below k digital
      assign pin_analog[i] = ~(port_config > CHAN); // see [RULE16]
      // converted only as analog input with no op-amp claim
      assign pin_convertible[i] = pin_analog[i] & pin_input_mode[i] &
        ~ref_pin_busy & (~amp_on | IS_AMP_OUT); // see [RULE21] see [RULE20]
      // op-amp output still usable as the conversion source
      assign pin_opamp_out[i] = amp_on & IS_AMP_OUT; // see [RULE20]
    end
  endgenerate

endmodule // arc_pin_map

`default_nettype wire

// ---- src/arc_top.v ----
// converter reference selection, channel, port config and result registers
//
// Functional notes
// [RULE1] level bit: clear 2.5 V, set 2.0 V
// [RULE2] software uses only six legal reference codes
// [RULE3] boost runs for external 2.0 or enabled output
// [RULE4] all-zero reference code only in normal mode 1
// [RULE5] software waits 10 us boost before conversion
// [RULE6] software sets select before enable
// [RULE7] software keeps level bit while reference enabled
// [RULE8] positive/negative reference chosen from control bits
// [RULE9] wide result 16 bits, top four zero
// [RULE10] upper four bits high byte, lower eight low
// [RULE11] wide result read-only, word read, resets zero
// [RULE12] high byte shows top eight result bits
// [RULE13] software reads result before config writes
// [RULE14] channel codes 0 to 10 and 15
// [RULE15] software writes zero to channel bits 7..4
// [RULE16] config k makes k lowest channels digital
// [RULE17] software uses input mode, never digital pins
// [RULE18] direction bit 0 output, 1 input, reset ff
// [RULE19] analog pins read as zero
// [RULE20] op-amp claims its pins except its output
// [RULE21] analog input pin converted when selected
// [RULE22] negative select: clear ground, set external pin
// [RULE23] both result views update on same edge
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.vh"

module arc_top #(
  parameter NPIN = 12
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // cpu register access
  input wire [19:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire cpu_word,
  input wire [7:0] cpu_wdata,
  output reg [15:0] cpu_rdata,
  output reg cpu_rvalid,
  // converter core
  input wire conv_done,
  input wire [11:0] sar_result,
  input wire [1:0] supply_mode,
  input wire [2:0] opamp_enable,
  // reference and boost controls
  output reg ref_level_2v0,
  output reg ref_output_on,
  output reg boost_enable,
  output reg pos_ref_internal,
  output reg neg_ref_external,
  output reg ref_mode_conflict,
  // channel controls
  output reg [3:0] conv_channel,
  output reg conv_channel_legal,
  output reg conv_channel_ok,
  output reg conv_from_opamp,
  // pins
  input wire [7:0] pin_level_p2,
  input wire [7:0] pin_level_p15,
  output reg [7:0] p2_out_enable,
  output reg [7:0] p15_out_enable,
  output reg [7:0] p2_pin_view,
  output reg [7:0] p15_pin_view,
  output reg [NPIN-1:0] pin_analog_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  reg [7:0] reference_voltage_control; // control bits
  reg [3:0] analog_channel_select; // channel code
  reg [4:0] port_analog_config; // analog/digital split
  reg [7:0] port_two_direction; // port 2 direction
  reg [3:0] port_fifteen_direction; // bits 7,2,1,0 kept
  reg [15:0] conversion_result_wide; // 12-bit result
  reg [7:0] conversion_result_high_byte; // top eight bits

  // decoded control bits
  wire neg_sel;
  wire ref_sel;
  wire lvl_sel;
  wire ref_en;
  wire [7:0] p15_dir;
  wire [NPIN-1:0] pin_input_mode;
  wire [NPIN-1:0] pin_analog;
  wire [NPIN-1:0] pin_convertible;
  wire [NPIN-1:0] pin_opamp_out;
  wire [3:0] chan_pin;
  wire chan_legal;
  reg [15:0] next_rdata;

  assign neg_sel = reference_voltage_control[`ARC_BIT_NEG_REF_SELECT];
  assign ref_sel = reference_voltage_control[`ARC_BIT_REF_OUTPUT_SELECT];
  assign lvl_sel = reference_voltage_control[`ARC_BIT_REF_LEVEL_SELECT];
  assign ref_en = reference_voltage_control[`ARC_BIT_REF_OUTPUT_ENABLE];

  // full port fifteen view with fixed ones
  assign p15_dir = {port_fifteen_direction[3], 4'hf,
    port_fifteen_direction[2:0]};

  // input mode per pin, pin 11 is channel 15 on bit 7
  assign pin_input_mode = {p15_dir[7], p15_dir[2:0], port_two_direction};

  ////////////////////////////////////////////////////////////////////////////
  // channel decode
  assign chan_legal = (analog_channel_select <= `ARC_CHAN_LAST_LOW) ||
    (analog_channel_select == `ARC_CHAN_FIFTEEN); // see [RULE14]
  // pin index: channel 15 maps to the last pin slot
  assign chan_pin = (analog_channel_select == `ARC_CHAN_FIFTEEN) ?
    4'hb : analog_channel_select;

  // per-pin decode
  arc_pin_map #(
    .NPIN(NPIN)
  ) u_pin_map (
    .port_config(port_analog_config),
    .pin_input_mode(pin_input_mode),
    .opamp_enable(opamp_enable),
    .negative_ref_select(neg_sel),
    .pin_analog(pin_analog),
    .pin_convertible(pin_convertible),
    .pin_opamp_out(pin_opamp_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes; byte writes only, result registers ignore writes
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reference_voltage_control <= `ARC_RST_REF_VOLTAGE_CTRL;
      analog_channel_select <= `ARC_RST_CHANNEL_SELECT; // see [RULE14]
      port_analog_config <= `ARC_RST_PORT_ANALOG_CONFIG; // see [RULE16]
      port_two_direction <= `ARC_RST_PORT_DIR; // see [RULE18]
      port_fifteen_direction <= 4'hf; // see [RULE18]
    end else if (cpu_wr) begin
      case (cpu_addr)
        `ARC_ADDR_REF_VOLTAGE_CTRL: begin
          // reserved bits stay zero
          reference_voltage_control <= cpu_wdata & `ARC_REF_CTRL_MASK;
        end
        `ARC_ADDR_CHANNEL_SELECT: begin
          // upper nibble held at zero
          analog_channel_select <= cpu_wdata[3:0];
        end
        `ARC_ADDR_PORT_ANALOG_CONFIG: begin
          port_analog_config <= cpu_wdata[4:0];
        end
        `ARC_ADDR_PORT_TWO_DIR: begin
          port_two_direction <= cpu_wdata; // see [RULE18]
        end
        `ARC_ADDR_PORT_FIFTEEN_DIR: begin
          // fixed bits 6..3 not stored
          port_fifteen_direction <= {cpu_wdata[7], cpu_wdata[2:0]};
        end
        default: begin
          // unmapped or read-only address, nothing stored
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture: both views load on the same edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result_wide <= `ARC_RST_RESULT_WIDE; // see [RULE11]
      conversion_result_high_byte <= `ARC_RST_RESULT_HIGH_BYTE; // see [RULE12]
    end else if (conv_done) begin
      // top four bits forced zero
      conversion_result_wide <= {4'h0, sar_result}; // see [RULE9] see [RULE10]
      conversion_result_high_byte <= sar_result[11:4]; // see [RULE12] see [RULE23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data selection
  always @* begin
    next_rdata = 16'h0000;
    case (cpu_addr)
      `ARC_ADDR_RESULT_WIDE_LO: begin
        // word read gives the whole result, byte read the low byte
        if (cpu_word) begin
          next_rdata = conversion_result_wide; // see [RULE11]
        end else begin
          next_rdata = {8'h00, conversion_result_wide[7:0]}; // see [RULE10]
        end
      end
      `ARC_ADDR_RESULT_HIGH_BYTE: begin
        // byte read of the high address gives the top eight bits
        next_rdata = {8'h00, conversion_result_high_byte}; // see [RULE12]
      end
      `ARC_ADDR_REF_VOLTAGE_CTRL: begin
        next_rdata = {8'h00, reference_voltage_control};
      end
      `ARC_ADDR_CHANNEL_SELECT: begin
        next_rdata = {12'h000, analog_channel_select};
      end
      `ARC_ADDR_PORT_ANALOG_CONFIG: begin
        next_rdata = {11'h000, port_analog_config};
      end
      `ARC_ADDR_PORT_TWO_DIR: begin
        next_rdata = {8'h00, port_two_direction};
      end
      `ARC_ADDR_PORT_FIFTEEN_DIR: begin
        next_rdata = {8'h00, p15_dir};
      end
      default: begin
        // unmapped addresses read zero
        next_rdata = 16'h0000;
      end
    endcase
  end

  // registered read answer one cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 16'h0000;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= cpu_rd;
      if (cpu_rd) begin
        cpu_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference, boost and channel outputs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_level_2v0 <= 1'b0;
      ref_output_on <= 1'b0;
      boost_enable <= 1'b0;
      pos_ref_internal <= 1'b0;
      neg_ref_external <= 1'b0;
      ref_mode_conflict <= 1'b0;
      conv_channel <= 4'h0;
      conv_channel_legal <= 1'b1;
      conv_channel_ok <= 1'b0;
      conv_from_opamp <= 1'b0;
    end else begin
      // level select: clear 2.5 V, set 2.0 V
      ref_level_2v0 <= lvl_sel; // see [RULE1]
      // reference output runs only when selected and enabled
      ref_output_on <= ref_sel & ref_en;
      // boost for external 2.0 setting or running reference
      boost_enable <= (lvl_sel & ~ref_sel) | (ref_sel & ref_en); // see [RULE3]
      // positive reference internal only when selected and enabled
      pos_ref_internal <= ref_sel & ref_en; // see [RULE8]
      // negative reference external pin or ground
      neg_ref_external <= neg_sel; // see [RULE8] see [RULE22]
      // all-zero reference code outside normal mode 1 is flagged
      ref_mode_conflict <= ~ref_sel & ~lvl_sel & ~ref_en &
        (supply_mode != `ARC_SUPPLY_NORMAL_ONE); // see [RULE4]
      conv_channel <= analog_channel_select; // see [RULE14]
      conv_channel_legal <= chan_legal; // see [RULE14]
      // selected pin must be eligible and the code legal
      conv_channel_ok <= chan_legal & pin_convertible[chan_pin]; // see [RULE21]
      conv_from_opamp <= chan_legal & pin_opamp_out[chan_pin]; // see [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin buffers and port data view
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p2_out_enable <= 8'h00;
      p15_out_enable <= 8'h00;
      p2_pin_view <= 8'h00;
      p15_pin_view <= 8'h00;
      pin_analog_mode <= {NPIN{1'b1}};
    end else begin
      // direction bit 0 turns the output buffer on
      p2_out_enable <= ~port_two_direction; // see [RULE18]
      p15_out_enable <= ~p15_dir; // see [RULE18]
      // analog pins read as zero whatever the level
      p2_pin_view <= pin_level_p2 & ~pin_analog[7:0]; // see [RULE19]
      p15_pin_view <= pin_level_p15 &
        ~{pin_analog[11], 4'h0, pin_analog[10:8]}; // see [RULE19]
      pin_analog_mode <= pin_analog; // see [RULE16]
    end
  end

endmodule // arc_top

`default_nettype wire

// ---- test/arc_top_sva.sv ----
// concurrent checks on the converter register block ports
`timescale 1ns/1ps
`default_nettype none
module arc_chk #(
  parameter NPIN = 12
) (
  // clock, reset and cpu bus
  input wire mclk,
  input wire rst_n,
  input wire [19:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire cpu_word,
  input wire [7:0] cpu_wdata,
  input wire [15:0] cpu_rdata,
  input wire cpu_rvalid,
  // converter core and pins
  input wire conv_done,
  input wire [11:0] sar_result,
  input wire [1:0] supply_mode,
  input wire [7:0] pin_level_p2,
  // derived outputs
  input wire ref_level_2v0,
  input wire ref_output_on,
  input wire boost_enable,
  input wire pos_ref_internal,
  input wire neg_ref_external,
  input wire ref_mode_conflict,
  input wire [3:0] conv_channel,
  input wire conv_channel_legal,
  input wire [7:0] p2_pin_view,
  input wire [NPIN-1:0] pin_analog_mode
);
  ////////////////////////////////////////////////////////////
  reg [7:0] ctl; // shadow of reference control
  reg [4:0] cfg; // shadow of port analog config
  reg [3:0] ch; // shadow of channel select
  reg [11:0] res; // last captured result
  reg warm; // high once derived outputs left reset
  wire [31:0] dig = (32'h1 << cfg) - 32'h1; // low k channels digital
  wire [11:0] am = ~{dig[15], dig[10:0]}; // expected analog map
  // shadows follow cpu writes and result captures
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 8'h00;
      cfg <= 5'h10;
      ch <= 4'h0;
      res <= 12'h000;
      warm <= 1'b0;
    end else begin
      warm <= 1'b1;
      if (conv_done) res <= sar_result;
      if (cpu_wr && cpu_addr == 20'hfff36) ctl <= cpu_wdata & 8'h8b;
      if (cpu_wr && cpu_addr == 20'hf0017) cfg <= cpu_wdata[4:0];
      if (cpu_wr && cpu_addr == 20'hfff31) ch <= cpu_wdata[3:0];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (warm |-> cpu_rvalid == $past(cpu_rd))
    else $error("read answer not one cycle after strobe");
  wide_read_a: assert property (cpu_rd && cpu_word && cpu_addr == 20'hfff1e
    |=> cpu_rdata == {4'h0, $past(res)}) else $error("wide result wrong");
  low_byte_a: assert property (cpu_rd && !cpu_word && cpu_addr == 20'hfff1e
    |=> cpu_rdata[7:0] == $past(res[7:0])) else $error("low byte wrong");
  high_byte_a: assert property (cpu_rd && cpu_addr == 20'hfff1f
    |=> cpu_rdata[7:0] == $past(res[11:4])) else $error("high byte wrong");
  ref_select_a: assert property (warm |-> {ref_level_2v0, pos_ref_internal,
    neg_ref_external, ref_output_on} == $past({ctl[1], ctl[3] & ctl[0],
    ctl[7], ctl[3] & ctl[0]})) else $error("reference outputs wrong");
  boost_run_a: assert property (warm |-> boost_enable ==
    $past(ctl[1] & !ctl[3] | ctl[3] & ctl[0])) else $error("boost wrong");
  mode_conflict_a: assert property (warm |-> ref_mode_conflict ==
    ($past(ctl[3:0] & 4'hb) == 4'h0 && $past(supply_mode) != 2'h0))
    else $error("conflict flag wrong");
  chan_legal_a: assert property (warm |-> conv_channel == $past(ch) &&
    conv_channel_legal == $past(ch <= 4'ha || ch == 4'hf))
    else $error("channel decode wrong");
  analog_map_a: assert property (warm |-> pin_analog_mode == $past(am))
    else $error("analog map wrong");
  pin_view_a: assert property (warm |-> p2_pin_view ==
    $past(pin_level_p2 & ~am[7:0])) else $error("pin view wrong");
  // main scenarios reached
  cover property (conv_done && cpu_rd);
  cover property (boost_enable && supply_mode != 2'h0);
  cover property (!conv_channel_legal);
endmodule // arc_chk
bind arc_top arc_chk #(.NPIN(NPIN)) u_chk (.*);
`default_nettype wire

// ---- test/tb_adc_reference_channel_result_regs.sv ----
// self-checking bench for the converter register block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_reference_channel_result_regs;
  ////////////////////////////////////////////////////////////
  logic mclk, rst_n, cpu_wr, cpu_rd, cpu_word, conv_done, cpu_rvalid;
  logic [19:0] cpu_addr;
  logic [7:0] cpu_wdata, pin_level_p2, pin_level_p15;
  logic [11:0] sar_result, am, pin_analog_mode;
  logic [1:0] supply_mode;
  logic [2:0] opamp_enable;
  logic [15:0] cpu_rdata;
  logic ref_level_2v0, ref_output_on, boost_enable, pos_ref_internal;
  logic neg_ref_external, ref_mode_conflict, conv_channel_legal;
  logic conv_channel_ok, conv_from_opamp;
  logic [3:0] conv_channel;
  logic [7:0] p2_out_enable, p15_out_enable, p2_pin_view, p15_pin_view;
  int n_mismatch, n_tests, cyc, i, k;
  // rows: control byte, supply mode, expected reference outputs
  // level bit only changes while the reference is disabled
  logic [15:0] rows [0:9] = '{16'h0000, 16'h0041, 16'h0228, 16'h0a20,
    16'h0bbc, 16'h0a20, 16'h0800, 16'h095c, 16'h8002, 16'h8083};
  wire [5:0] refv = {ref_level_2v0, ref_output_on, boost_enable,
    pos_ref_internal, neg_ref_external, ref_mode_conflict};
  arc_top #(.NPIN(12)) dut_u (.*);
  ////////////////////////////////////////////////////////////
  // free running clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  // compare one value
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // byte write, then one cycle for derived outputs
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge mclk);
    cpu_wr = 1'b0;
    @(negedge mclk);
  endtask
  // read and compare the answer while rvalid stands
  task automatic rd(input logic [19:0] a, input logic w, input logic [15:0] e);
    cpu_addr = a;
    cpu_word = w;
    cpu_rd = 1'b1;
    @(negedge mclk);
    cpu_rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0, cpu_rvalid});
    chk("rdata", e, cpu_rdata);
  endtask
  // channel choice against conversion eligibility
  task automatic okc(input logic [2:0] op, input logic [7:0] c, input logic [1:0] e);
    opamp_enable = op;
    wr(20'hfff31, c);
    chk("conv_ok", {14'h0, e}, {14'h0, conv_channel_ok, conv_from_opamp});
  endtask
  // verdict
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n, cpu_wr, cpu_rd, cpu_word, conv_done, cpu_addr} = '0;
    {cpu_wdata, sar_result, supply_mode, opamp_enable} = '0;
    {pin_level_p2, pin_level_p15, n_mismatch, n_tests, cyc} = '0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    for (i = 0; i < 10; i++) begin
      supply_mode = rows[i][7:6];
      wr(20'hfff36, rows[i][15:8]);
      chk("ref", {10'h0, rows[i][5:0]}, {10'h0, refv});
    end
    $display("test reference rows done");
    wr(20'hfff36, 8'h00);
    rd(20'hf0017, 1'b0, 16'h0010);
    rd(20'hfff22, 1'b0, 16'h00ff);
    rd(20'hfff2f, 1'b0, 16'h00ff);
    rd(20'hfff31, 1'b0, 16'h0000);
    rd(20'hfff1e, 1'b1, 16'h0000);
    rd(20'hfff1f, 1'b0, 16'h0000);
    wr(20'hfff36, 8'h8a);
    wr(20'hfff36, 8'hff);
    rd(20'hfff36, 1'b0, 16'h008b);
    $display("test reset values done");
    sar_result = 12'habc;
    conv_done = 1'b1;
    @(negedge mclk);
    conv_done = 1'b0;
    rd(20'hfff1e, 1'b1, 16'h0abc);
    rd(20'hfff1e, 1'b0, 16'h00bc);
    rd(20'hfff1f, 1'b0, 16'h00ab);
    cpu_addr = 20'hfff1e;
    cpu_word = 1'b1;
    sar_result = 12'h123;
    conv_done = 1'b1;
    cpu_rd = 1'b1;
    @(negedge mclk);
    {conv_done, cpu_rd} = 2'b00;
    @(negedge mclk);
    chk("same_edge", 16'h0abc, cpu_rdata);
    wr(20'hfff1e, 8'hff);
    rd(20'hfff1e, 1'b1, 16'h0123);
    rd(20'hfff1f, 1'b0, 16'h0012);
    rd(20'hfff40, 1'b0, 16'h0000);
    $display("test results done");
    for (i = 0; i < 16; i++) begin
      wr(20'hfff31, i[7:0]);
      chk("chan", i[15:0], {12'h0, conv_channel});
      chk("legal", {15'h0, i <= 10 || i == 15},
        {15'h0, conv_channel_legal});
    end
    $display("test channels done");
    {pin_level_p2, pin_level_p15} = 16'hffff;
    for (k = 0; k < 17; k++) begin
      wr(20'hf0017, k[7:0]);
      for (i = 0; i < 11; i++) am[i] = !(k > i);
      am[11] = !(k > 15);
      chk("analog", {4'h0, am}, {4'h0, pin_analog_mode});
      chk("view2", {8'h0, ~am[7:0]}, {8'h0, p2_pin_view});
      chk("view15", {8'h0, ~am[11], 4'hf, ~am[10:8]},
        {8'h0, p15_pin_view});
    end
    $display("test port config done");
    wr(20'hfff22, 8'h5a);
    chk("oe2", 16'h00a5, {8'h0, p2_out_enable});
    wr(20'hfff2f, 8'h00);
    chk("oe15", 16'h0087, {8'h0, p15_out_enable});
    rd(20'hfff2f, 1'b0, 16'h0078);
    wr(20'hfff22, 8'hf7);
    wr(20'hfff2f, 8'hff);
    wr(20'hfff36, 8'h8a);
    wr(20'hfff36, 8'h00);
    wr(20'hf0017, 8'h00);
    okc(3'h0, 8'h03, 2'b00);
    wr(20'hfff22, 8'hff);
    okc(3'h0, 8'h03, 2'b10);
    okc(3'h2, 8'h03, 2'b00);
    okc(3'h2, 8'h04, 2'b11);
    okc(3'h0, 8'h0f, 2'b10);
    wr(20'hfff36, 8'h80);
    okc(3'h0, 8'h0f, 2'b00);
    $display("test eligibility done");
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    rd(20'hfff36, 1'b0, 16'h0000);
    rd(20'hfff1e, 1'b1, 16'h0000);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule // tb_adc_reference_channel_result_regs
`default_nettype wire
